// file: rtl/mult_col_pkg.sv
`default_nettype none
package mult_col_pkg;
  // Operand and product widths of one multiplier slice.
  localparam int OPND_W = 18;
  localparam int PROD_W = 36;
  // Number of slices stacked in one column.
  localparam int COL_DEPTH = 4;
  // Stage presence defaults: 1 inserts the register, 0 bypasses it.
  localparam bit STAGE_ON = 1'b1;
  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets.
  localparam logic [7:0] SRC_SEL_OFS = 8'h00;  // Per-slice operand source select.
  localparam logic [7:0] STEP_OFS    = 8'h04;  // Stage enable and clear pulses.
  localparam logic [3:0] OPA_GRP     = 4'h1;   // First operands at 0x10 + 4*slice.
  localparam logic [3:0] OPB_GRP     = 4'h2;   // Direct second operands at 0x20 + 4*slice.
  localparam logic [3:0] PLO_GRP     = 4'h3;   // Product bits 31:0 at 0x30 + 4*slice.
  localparam logic [3:0] PHI_GRP     = 4'h4;   // Product bits 35:32 at 0x40 + 4*slice.
  localparam logic [3:0] CHN_GRP     = 4'h5;   // Chain outputs at 0x50 + 4*slice.
  // Field positions inside the pulse register.
  localparam int STEP_CE_LSB  = 0;             // Bits 2:0 enable first, second, product.
  localparam int STEP_CLR_LSB = 4;             // Bits 6:4 clear first, second, product.
  // Reset values.
  localparam logic [COL_DEPTH-1:0] SRC_SEL_RST = '0;  // All slices take the direct input.
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  // Bus channel states, Gray coded.
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_RESP = 2'b01
  } chan_state_t;
endpackage
`default_nettype wire

// file: rtl/slice_ctrl_if.sv
`default_nettype none
// Shared stage controls from the column controller to every slice.
interface slice_ctrl_if;
  logic ce_a;   // First operand stage enable.
  logic ce_b;   // Second operand stage enable.
  logic ce_p;   // Product stage enable.
  logic clr_a;  // First operand stage synchronous clear.
  logic clr_b;  // Second operand stage synchronous clear.
  logic clr_p;  // Product stage synchronous clear.
  modport ctl   (output ce_a, ce_b, ce_p, clr_a, clr_b, clr_p);
  modport stage (input ce_a, ce_b, ce_p, clr_a, clr_b, clr_p);
endinterface
`default_nettype wire

// file: rtl/multiplier_slice.sv
`default_nettype none
module multiplier_slice
  import mult_col_pkg::*;
#(
  parameter bit FIRST_OPERAND_STAGE  = STAGE_ON,
  parameter bit SECOND_OPERAND_STAGE = STAGE_ON,
  parameter bit PRODUCT_STAGE        = STAGE_ON
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  slice_ctrl_if.stage                     ctl,
  input  wire logic                       src_cascade,
  input  wire logic [mult_col_pkg::OPND_W-1:0] a_in,
  input  wire logic [mult_col_pkg::OPND_W-1:0] b_in,
  input  wire logic [mult_col_pkg::OPND_W-1:0] operand_chain_in,
  output logic      [mult_col_pkg::OPND_W-1:0] operand_chain_out,
  output logic      [mult_col_pkg::PROD_W-1:0] p_out
);
  import mult_col_pkg::*;

  // Full-precision signed product of two operands.
  function automatic logic [PROD_W-1:0] smul(input logic [OPND_W-1:0] x,
                                             input logic [OPND_W-1:0] y);
    logic signed [PROD_W-1:0] xs;
    logic signed [PROD_W-1:0] ys;
    xs = $signed({{(PROD_W-OPND_W){x[OPND_W-1]}}, x});
    ys = $signed({{(PROD_W-OPND_W){y[OPND_W-1]}}, y});
    return PROD_W'(xs * ys);
  endfunction

  logic [OPND_W-1:0] a_r;     // First operand stage.
  logic [OPND_W-1:0] b_r;     // Second operand stage.
  logic [PROD_W-1:0] p_r;     // Product stage.
  logic [OPND_W-1:0] b_sel;   // Selected second operand source.
  logic [OPND_W-1:0] a_used;  // First operand applied to the multiplier.
  logic [OPND_W-1:0] b_used;  // Second operand applied to the multiplier.
  logic [PROD_W-1:0] prod;    // Combinational product.

  // The cascade setting takes the neighbour's operand instead of the direct input.
  assign b_sel  = src_cascade ? operand_chain_in : b_in;  // RULE1 RULE2
  // A stage set to 0 is a plain wire.
  assign a_used = FIRST_OPERAND_STAGE ? a_r : a_in;  // RULE19
  assign b_used = SECOND_OPERAND_STAGE ? b_r : b_sel;  // RULE3 RULE19
  assign prod   = smul(a_used, b_used);  // RULE17
  assign p_out  = PRODUCT_STAGE ? p_r : prod;  // RULE19
  // The chain output always shows the operand actually used.
  assign operand_chain_out = b_used;  // RULE4

  // Operand stages: clear wins over enable, each adds one cycle of latency.
  always_ff @(posedge aclk) begin
    if (!aresetn || ctl.clr_a) begin  // RULE18
      a_r <= '0;
    end else if (ctl.ce_a) begin  // RULE20
      a_r <= a_in;
    end
    if (!aresetn || ctl.clr_b) begin  // RULE18
      b_r <= '0;
    end else if (ctl.ce_b) begin  // RULE3 RULE20
      b_r <= b_sel;
    end
  end

  // Product stage with its own enable and clear.
  always_ff @(posedge aclk) begin
    if (!aresetn || ctl.clr_p) begin  // RULE18
      p_r <= '0;
    end else if (ctl.ce_p) begin  // RULE20
      p_r <= prod;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_src_cascade: assert property (src_cascade |-> b_sel == operand_chain_in)  // RULE2
    else $error("Cascade setting did not route the chain input.");
  a_second_operand_stage_capture: assert property (SECOND_OPERAND_STAGE && ctl.ce_b && !ctl.clr_b  // RULE3
      |=> operand_chain_out == $past(b_sel))
    else $error("Second operand stage missed the selected value.");
  a_second_operand_stage_clear: assert property (SECOND_OPERAND_STAGE && ctl.clr_b  // RULE18
      |=> operand_chain_out == '0)
    else $error("Second operand stage not cleared.");
  a_second_operand_stage_hold: assert property (SECOND_OPERAND_STAGE && !ctl.ce_b && !ctl.clr_b  // RULE18
      |=> $stable(operand_chain_out))
    else $error("Second operand stage changed without enable.");
  a_prod_latency: assert property (PRODUCT_STAGE && ctl.ce_p && !ctl.clr_p  // RULE20
      |=> p_out == smul($past(a_used), $past(operand_chain_out)))
    else $error("Product stage did not show the product one cycle later.");
  a_prod_value: assert property (!PRODUCT_STAGE  // RULE17
      |-> p_out == smul(a_used, operand_chain_out))
    else $error("Bypassed product is wrong.");
endmodule  // multiplier_slice
`default_nettype wire

// file: rtl/multiplier_column.sv
`default_nettype none
// Operation
// (RULE1) Static setting picks direct or cascade operand.
// (RULE2) Cascade setting routes chain input to multiplier.
// (RULE3) Optional stage captures selected operand, else passes.
// (RULE4) Chain output shows operand actually applied.
// (RULE5) Each chain output feeds slice directly above.
// (RULE6) Bottom chain input unconnected, top output unused.
// (RULE7) Registered chain shifts one slice per enable.
// (RULE8) Unregistered chain broadcasts one operand to all.
// (RULE9) Fabric splits wide operands, keeping weight, sign.
// (RULE10) Low partial bits bypass adder; signed sign-extended.
// (RULE11) Four partial products for two wide operands.
// (RULE12) 35x35 uses four slices, 53-bit adder.
// (RULE13) Unsigned 34x34 ties operand MSBs to zero.
// (RULE14) Two values packed: one shifted, one low.
// (RULE15) Packed squares need non-overlapping term ranges.
// (RULE16) Packed sizes from 6x6/5x5 to 4x4/7x7.
// (RULE17) Slice forms full 36-bit signed product.
// (RULE18) Stages share clock, own enable and clear.
// (RULE19) Stage setting 1 inserts, 0 bypasses; default 1.
// (RULE20) Each inserted stage adds exactly one cycle.
module multiplier_column
  import mult_col_pkg::*;
#(
  parameter int N                    = COL_DEPTH,
  parameter bit FIRST_OPERAND_STAGE  = STAGE_ON,
  parameter bit SECOND_OPERAND_STAGE = STAGE_ON,
  parameter bit PRODUCT_STAGE        = STAGE_ON
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [mult_col_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [mult_col_pkg::DATA_W-1:0]   wdata,
  input  wire logic [mult_col_pkg::DATA_W/8-1:0] wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  input  wire logic [mult_col_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [mult_col_pkg::DATA_W-1:0]        rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready
);
  import mult_col_pkg::*;

  // True when an address falls on a mapped register.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] ad);
    logic [3:0] grp;
    grp = ad[7:4];
    if (grp == 4'h0) begin
      return (ad[3:0] == SRC_SEL_OFS[3:0]) || (ad[3:0] == STEP_OFS[3:0]);
    end
    return (grp >= OPA_GRP) && (grp <= CHN_GRP) && (32'(ad[3:2]) < N);
  endfunction

  // Merge a written word into a stored value under byte enables.
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] nw,
                                              input logic [DATA_W/8-1:0] st);
    logic [DATA_W-1:0] res;
    res = old;
    for (int k = 0; k < DATA_W/8; k++) begin
      if (st[k]) begin
        res[8*k +: 8] = nw[8*k +: 8];
      end
    end
    return res;
  endfunction

  slice_ctrl_if ctl_bus ();                 // Stage controls shared by all slices.
  chan_state_t       wstate_r;              // Write channel state.
  chan_state_t       rstate_r;              // Read channel state.
  logic              awready_r;             // Write address ready.
  logic              wready_r;              // Write data ready.
  logic              bvalid_r;              // Write response valid.
  logic [1:0]        bresp_r;               // Write response code.
  logic              arready_r;             // Read address ready.
  logic              rvalid_r;              // Read data valid.
  logic [1:0]        rresp_r;               // Read response code.
  logic [DATA_W-1:0] rdata_r;               // Read data.
  logic              aw_held_r;             // Write address captured.
  logic              w_held_r;              // Write data captured.
  logic [ADDR_W-1:0] aw_addr_r;             // Captured write address.
  logic [DATA_W-1:0] w_data_r;              // Captured write data.
  logic [DATA_W/8-1:0] w_strb_r;            // Captured byte enables.
  logic [N-1:0]      src_sel_r;             // Per-slice cascade select.
  logic [6:0]        step_r;                // One-cycle stage pulses.
  logic [OPND_W-1:0] opa_r [N];             // First operand per slice.
  logic [OPND_W-1:0] opb_r [N];             // Direct second operand per slice.
  logic [OPND_W-1:0] chain_w [N];           // Chain output of each slice.
  logic [PROD_W-1:0] prod_w [N];            // Product of each slice.
  logic              wr_go;                 // Write commits this cycle.
  logic [1:0]        wr_slot;               // Slice index of the write.
  logic [3:0]        wr_grp;                // Register group of the write.
  logic [1:0]        rd_slot;               // Slice index of the read.
  logic [3:0]        rd_grp;                // Register group of the read.
  logic [DATA_W-1:0] rd_word;               // Read data selected by address.

  assign wr_go   = (wstate_r == CH_IDLE) && aw_held_r && w_held_r;
  assign wr_slot = aw_addr_r[3:2];
  assign wr_grp  = aw_addr_r[7:4];
  assign rd_slot = araddr[3:2];
  assign rd_grp  = araddr[7:4];

  // Read selection; unmapped words read as zero.
  always_comb begin
    rd_word = '0;
    if (araddr == SRC_SEL_OFS) begin
      rd_word = DATA_W'(src_sel_r);
    end else if (is_mapped(araddr) && rd_grp != 4'h0) begin
      case (rd_grp)
        OPA_GRP: rd_word = DATA_W'(opa_r[rd_slot]);
        OPB_GRP: rd_word = DATA_W'(opb_r[rd_slot]);
        PLO_GRP: rd_word = prod_w[rd_slot][31:0];
        PHI_GRP: rd_word = DATA_W'(prod_w[rd_slot][PROD_W-1:32]);
        CHN_GRP: rd_word = DATA_W'(chain_w[rd_slot]);
        default: rd_word = '0;
      endcase
    end
  end

  // Write channel: address and data taken in either order, then one response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_r  <= CH_IDLE;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (awvalid && awready_r) begin
        aw_addr_r <= awaddr;
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r  <= 1'b1;
        bresp_r   <= is_mapped(aw_addr_r) ? RESP_OKAY : RESP_DECERR;
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        wstate_r  <= CH_RESP;
      end else if (wstate_r == CH_RESP && bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
        wstate_r  <= CH_IDLE;
      end
    end
  end

  // Read channel: data is registered at the same edge that takes the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate_r  <= CH_IDLE;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= '0;
    end else if (rstate_r == CH_IDLE && arvalid) begin
      rdata_r   <= rd_word;
      rresp_r   <= is_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      rvalid_r  <= 1'b1;
      arready_r <= 1'b0;
      rstate_r  <= CH_RESP;
    end else if (rstate_r == CH_RESP && rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
      rstate_r  <= CH_IDLE;
    end
  end

  // Software-visible configuration, operands and stage pulses.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_sel_r <= SRC_SEL_RST[N-1:0];
      step_r    <= '0;
      for (int i = 0; i < N; i++) begin
        opa_r[i] <= '0;
        opb_r[i] <= '0;
      end
    end else begin
      step_r <= '0;
      if (wr_go && aw_addr_r == SRC_SEL_OFS) begin
        src_sel_r <= N'(merge(DATA_W'(src_sel_r), w_data_r, w_strb_r));  // RULE1
      end
      if (wr_go && aw_addr_r == STEP_OFS && w_strb_r[0]) begin
        step_r <= w_data_r[6:0];  // RULE18
      end
      if (wr_go && is_mapped(aw_addr_r) && wr_grp == OPA_GRP) begin
        opa_r[wr_slot] <= OPND_W'(merge(DATA_W'(opa_r[wr_slot]), w_data_r, w_strb_r));
      end
      if (wr_go && is_mapped(aw_addr_r) && wr_grp == OPB_GRP) begin
        opb_r[wr_slot] <= OPND_W'(merge(DATA_W'(opb_r[wr_slot]), w_data_r, w_strb_r));
      end
    end
  end

  assign ctl_bus.ce_a  = step_r[STEP_CE_LSB];
  assign ctl_bus.ce_b  = step_r[STEP_CE_LSB+1];
  assign ctl_bus.ce_p  = step_r[STEP_CE_LSB+2];
  assign ctl_bus.clr_a = step_r[STEP_CLR_LSB];
  assign ctl_bus.clr_b = step_r[STEP_CLR_LSB+1];
  assign ctl_bus.clr_p = step_r[STEP_CLR_LSB+2];

  // The column: each chain output drives the chain input of the slice above.
  for (genvar i = 0; i < N; i++) begin : g_slice
    logic [OPND_W-1:0] chain_in;  // Chain input of this slice.
    if (i == 0) begin : g_bottom
      assign chain_in = '0;  // RULE6
    end else begin : g_upper
      assign chain_in = chain_w[i-1];  // RULE5
    end
    multiplier_slice #(
      .FIRST_OPERAND_STAGE  (FIRST_OPERAND_STAGE),
      .SECOND_OPERAND_STAGE (SECOND_OPERAND_STAGE),
      .PRODUCT_STAGE        (PRODUCT_STAGE)
    ) u_slice (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .ctl               (ctl_bus.stage),
      .src_cascade       (src_sel_r[i]),
      .a_in              (opa_r[i]),
      .b_in              (opb_r[i]),
      .operand_chain_in  (chain_in),
      .operand_chain_out (chain_w[i]),
      .p_out             (prod_w[i])
    );
    if (i > 0) begin : g_chk
      a_chain_shift: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE7
          SECOND_OPERAND_STAGE && src_sel_r[i] && ctl_bus.ce_b && !ctl_bus.clr_b
          |=> chain_w[i] == $past(chain_w[i-1]))
        else $error("Registered chain did not shift by one slice.");
      a_chain_bcast: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE8
          !SECOND_OPERAND_STAGE && src_sel_r[i] |-> chain_w[i] == chain_w[i-1])
        else $error("Unregistered chain did not broadcast.");
    end
  end
  // The top slice's chain output feeds no slice; it is only read back through the chain output registers.

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;

  a_bottom_open: assert property (@(posedge aclk) disable iff (!aresetn)  // RULE6
      src_sel_r[0] && !SECOND_OPERAND_STAGE |-> chain_w[0] == '0)
    else $error("Bottom slice chain input is not unconnected.");
endmodule  // multiplier_column
`default_nettype wire

// file: tb/fabric_master.sv
`default_nettype none
// Fabric-side bus master that feeds operands and fetches products over the register bus.
module fabric_master
  import mult_col_pkg::*;
(
  input  wire logic                              aclk,
  output logic      [mult_col_pkg::ADDR_W-1:0]   awaddr,
  output logic                                   awvalid,
  input  wire logic                              awready,
  output logic      [mult_col_pkg::DATA_W-1:0]   wdata,
  output logic      [mult_col_pkg::DATA_W/8-1:0] wstrb,
  output logic                                   wvalid,
  input  wire logic                              wready,
  input  wire logic [1:0]                        bresp,
  input  wire logic                              bvalid,
  output logic                                   bready,
  output logic      [mult_col_pkg::ADDR_W-1:0]   araddr,
  output logic                                   arvalid,
  input  wire logic                              arready,
  input  wire logic [mult_col_pkg::DATA_W-1:0]   rdata,
  input  wire logic [1:0]                        rresp,
  input  wire logic                              rvalid,
  output logic                                   rready
);
  timeunit 1ns;
  timeprecision 1ns;
  import mult_col_pkg::*;

  // All requests start idle so nothing is offered during reset.
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // One write; released payloads are inverted so stale values never look valid.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        done = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask

  // One read; data and response are taken at the edge that sees rvalid.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        done = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
endmodule // fabric_master
`default_nettype wire

// file: tb/multiplier_column_tb.sv
`default_nettype none
// Bench for the multiplier column seen through its register bus.
module multiplier_column_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mult_col_pkg::*;
  logic        aclk = 1'b0;      // 10 MHz clock.
  logic        aresetn = 1'b0;   // Synchronous reset, active low.
  logic [7:0]  awaddr, araddr;   // Bus addresses.
  logic [31:0] wdata, rdata;     // Bus data.
  logic [3:0]  wstrb;            // Byte lanes.
  logic [1:0]  bresp, rresp;     // Responses.
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          errors = 0;       // Mismatches seen.
  int          comparisons = 0;  // Checks made.
  int          cycles = 0;       // Hang guard.
  logic [17:0] av [4] = '{18'h3fffd, 18'h20000, 18'h1ffff, 18'h00001};
  logic [17:0] bv [4] = '{18'h00005, 18'h20000, 18'h20000, 18'h3ffff};
  logic [35:0] pv [4];           // Expected products.

  always #50 aclk = ~aclk;

  multiplier_column #(.N(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  fabric_master i_fab (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // Prints the verdict and stops the run.
  task automatic print_verdict;
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compares a data word.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compares a bus response code.
  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write and judge the response.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_fab.wr(a, d, r);
    chk_resp("bresp", er, r);
  endtask

  // Read and judge response and data.
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    i_fab.rd(a, d, r);
    chk_resp("rresp", er, r);
    chk(nm, e, d);
  endtask

  // Reset values and unmapped places.
  task automatic t_reset;
    rd("src_sel", SRC_SEL_OFS, 32'h0, RESP_OKAY);
    rd("prod_lo", 8'h30, 32'h0, RESP_OKAY);
    rd("unmapped", 8'h60, 32'h0, RESP_DECERR);
    wr(8'h08, 32'h1, RESP_DECERR);
    rd("step_reads_zero", STEP_OFS, 32'h0, RESP_OKAY);
  endtask

  // Signed products on all slices, one cycle per stage.
  task automatic t_mult;
    for (int i = 0; i < 4; i++) begin
      pv[i] = $signed(av[i]) * $signed(bv[i]);
      wr({OPA_GRP, 2'(i), 2'b00}, {{14{av[i][17]}}, av[i]}, RESP_OKAY);
      wr({OPB_GRP, 2'(i), 2'b00}, {{14{bv[i][17]}}, bv[i]}, RESP_OKAY);
    end
    wr(STEP_OFS, 32'h3, RESP_OKAY);
    rd("prod_early", 8'h34, 32'h0, RESP_OKAY);
    wr(STEP_OFS, 32'h4, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      rd("prod_lo", {PLO_GRP, 2'(i), 2'b00}, pv[i][31:0], RESP_OKAY);
      rd("prod_hi", {PHI_GRP, 2'(i), 2'b00}, {28'h0, pv[i][35:32]}, RESP_OKAY);
    end
  endtask

  // Separate clears, clear winning over enable.
  task automatic t_clear;
    wr(STEP_OFS, 32'h44, RESP_OKAY);
    rd("prod_cleared", 8'h34, 32'h0, RESP_OKAY);
    wr(STEP_OFS, 32'h4, RESP_OKAY);
    rd("prod_reload", 8'h34, pv[1][31:0], RESP_OKAY);
    wr(STEP_OFS, 32'h10, RESP_OKAY);
    wr(STEP_OFS, 32'h4, RESP_OKAY);
    rd("prod_a_clear", 8'h44, 32'h0, RESP_OKAY);
  endtask

  // Registered chain shifts one slice per second-stage enable.
  task automatic t_chain;
    wr(SRC_SEL_OFS, 32'he, RESP_OKAY);
    wr(8'h20, 32'h7, RESP_OKAY);
    wr(8'h2c, 32'h155, RESP_OKAY);
    wr(STEP_OFS, 32'h20, RESP_OKAY);
    wr(STEP_OFS, 32'h2, RESP_OKAY);
    rd("chain0", 8'h50, 32'h7, RESP_OKAY);
    rd("chain1", 8'h54, 32'h0, RESP_OKAY);
    rd("chain3", 8'h5c, 32'h0, RESP_OKAY);
    wr(STEP_OFS, 32'h2, RESP_OKAY);
    rd("chain1", 8'h54, 32'h7, RESP_OKAY);
    wr(8'h20, 32'hffffffff, RESP_OKAY);
    rd("chain0_held", 8'h50, 32'h7, RESP_OKAY);
    wr(STEP_OFS, 32'h2, RESP_OKAY);
    rd("chain0", 8'h50, 32'h3ffff, RESP_OKAY);
    rd("chain2", 8'h58, 32'h7, RESP_OKAY);
    rd("chain3", 8'h5c, 32'h0, RESP_OKAY);
    wr(SRC_SEL_OFS, 32'hf, RESP_OKAY);
    rd("src_sel", SRC_SEL_OFS, 32'hf, RESP_OKAY);
    wr(STEP_OFS, 32'h2, RESP_OKAY);
    rd("chain0_bottom", 8'h50, 32'h0, RESP_OKAY);
    rd("chain1", 8'h54, 32'h3ffff, RESP_OKAY);
  endtask

  // Loads both operand stages, then the product stage, on every slice.
  task automatic step_all;
    wr(STEP_OFS, 32'h3, RESP_OKAY);
    wr(STEP_OFS, 32'h4, RESP_OKAY);
  endtask

  // Fetches one slice's 36-bit product for the fabric-side arithmetic.
  task automatic get_prod(input int s, output logic [35:0] p);
    logic [31:0] d;
    logic [1:0]  r;
    i_fab.rd({PLO_GRP, 2'(s), 2'b00}, d, r);
    chk_resp("rresp", RESP_OKAY, r);
    p[31:0] = d;
    i_fab.rd({PHI_GRP, 2'(s), 2'b00}, d, r);
    chk_resp("rresp", RESP_OKAY, r);
    p[35:32] = d[3:0];
  endtask

  // A 35x35 signed product built from four slices and two fabric adders.
  task automatic t_wide;
    logic signed [34:0] x;
    logic signed [34:0] y;
    logic signed [69:0] ref_p;  // Reference product.
    logic [17:0]        opa [4];
    logic [17:0]        opb [4];
    logic [35:0]        pp [4];   // Partial products.
    logic [69:0]        cat;      // Low and high products side by side.
    logic [52:0]        s1;       // Sum of the two cross products.
    logic [52:0]        s2;       // Fixed adder output.
    x = 35'h58a3c1e77;
    y = 35'h31f0e9a25;
    ref_p = x * y;
    opa = '{{1'b0, x[16:0]}, x[34:17], {1'b0, x[16:0]}, x[34:17]};
    opb = '{{1'b0, y[16:0]}, {1'b0, y[16:0]}, y[34:17], y[34:17]};
    wr(SRC_SEL_OFS, 32'h0, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr({OPA_GRP, 2'(i), 2'b00}, 32'(opa[i]), RESP_OKAY);
      wr({OPB_GRP, 2'(i), 2'b00}, 32'(opb[i]), RESP_OKAY);
    end
    step_all();
    for (int i = 0; i < 4; i++) begin
      get_prod(i, pp[i]);
    end
    cat = {pp[3], pp[0][33:0]};
    s1 = {{17{pp[1][35]}}, pp[1]} + {{17{pp[2][35]}}, pp[2]};
    s2 = cat[69:17] + s1;
    chk("wide_lo", ref_p[31:0], {s2[14:0], cat[16:0]});
    chk("wide_mid", ref_p[63:32], s2[46:15]);
    chk("wide_hi", 32'(ref_p[69:64]), 32'(s2[52:47]));
  endtask

  // Two squarings packed into slice 0 and pulled apart again.
  task automatic t_pack;
    logic signed [5:0]  x;
    logic [4:0]         y;
    logic [17:0]        v;   // Packed operand.
    logic [35:0]        p;   // Slice product.
    logic signed [35:0] hi;  // Product rounded at the high field.
    x = -6'sd27;
    y = 5'd29;
    // A 12-place shift keeps the cross term clear of both squares.
    v = {x, 12'h000} + {13'h0, y};
    wr({OPA_GRP, 4'h0}, 32'(v), RESP_OKAY);
    wr({OPB_GRP, 4'h0}, 32'(v), RESP_OKAY);
    step_all();
    get_prod(0, p);
    hi = $signed(p) + 36'sh000800000;
    chk("pack_low_sq", 32'(y) * 32'(y), 32'(p[12:0]));
    chk("pack_high_sq", 32'(x) * 32'(x), 32'(hi >>> 24));
  endtask

  // Hang guard: far above the few hundred cycles the sequence needs.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // Main sequence: reset for 12 cycles, then the scenarios.
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mult();
    t_clear();
    t_chain();
    t_wide();
    t_pack();
    print_verdict();
  end
endmodule // multiplier_column_tb
`default_nettype wire
